// [shared/taganti_pkg.sv]
// constants for the tag anticollision responder
package taganti_pkg;
    localparam logic [7:0] CMD_PREFIX = 8'h06;
    localparam logic [7:0] SUB_BEGIN_INV = 8'h00;
    localparam logic [7:0] SUB_SLOT_ZERO = 8'h04;
    localparam logic [3:0] SLOT_CALL_NIBBLE = 4'h6;
    localparam logic [7:0] PICK_CODE = 8'h0e;
    localparam logic [7:0] COMPLETE_CODE = 8'h0f;
    localparam int ID_W = 8;
    localparam int SLOT_W = 4;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;
    typedef enum logic [2:0] {
        TAGANTI_READY = 3'b000,
        TAGANTI_INVENTORY = 3'b001,
        TAGANTI_SELECTED = 3'b010,
        TAGANTI_DESELECTED = 3'b011,
        TAGANTI_DEACTIVATED = 3'b100
    } taganti_state_t;
endpackage

// [rtl/taganti_rng.sv]
// free-running galois lfsr supplying random bits to the responder
`timescale 1ns/1ps
`default_nettype none
module taganti_rng
    import taganti_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // random output
    output logic [WIDTH-1:0] rnd
);
    initial begin
        if (WIDTH != 16) $error("taganti_rng: only 16 bit lfsr supported");
    end
    logic [15:0] lfsr_r;
    wire [15:0] lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lfsr_r <= LFSR_SEED;
        end else begin
            lfsr_r <= lfsr_nxt;
        end
    end
    assign rnd = lfsr_r;
endmodule
`default_nettype wire

// [rtl/taganti_responder.sv]
// tag-side anticollision responder: state gate, random ids, slot answers
// Function
// - slot commands answered only in inventory
// - ready tag ignores everything but begin-inventory
// - every ready or inventory tag answers begin-inventory
// - ready state holds a random short identifier
// - low identifier nibble is the slot index
// - slot zero call redraws index, answers on zero
// - slot call answers when index matches number
// - command codes 06-00, 06-04, x6
`timescale 1ns/1ps
`default_nettype none
module taganti_responder
    import taganti_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // decoded request frame from the frame decoder, same clock
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte0,
    input wire logic [7:0] cmd_byte1,
    input wire logic cmd_two_bytes,
    // answer request to the frame encoder
    output logic answer_valid,
    output logic [7:0] tag_short_identifier,
    // state view for other blocks
    output logic [2:0] tag_state
);
    taganti_state_t state_r, state_nxt;
    logic [7:0] id_r, id_nxt;
    logic answer_valid_r;
    logic [15:0] rnd;

    taganti_rng #(.WIDTH(16)) u_rng (
        .mclk(mclk),
        .reset_n(reset_n),
        .rnd(rnd)
    );

    // command decode
    wire is_begin_inv = cmd_valid && cmd_two_bytes && cmd_byte0 == CMD_PREFIX
                        && cmd_byte1 == SUB_BEGIN_INV;
    wire is_slot_zero = cmd_valid && cmd_two_bytes && cmd_byte0 == CMD_PREFIX
                        && cmd_byte1 == SUB_SLOT_ZERO;
    // high nibble zero is reserved for the slot zero call
    wire is_slot_call = cmd_valid && !cmd_two_bytes && cmd_byte0[3:0] == SLOT_CALL_NIBBLE
                        && cmd_byte0[7:4] != 4'h0;
    wire [3:0] slot_number_param = cmd_byte0[7:4];
    wire is_pick = cmd_valid && cmd_two_bytes && cmd_byte0 == PICK_CODE;
    wire pick_match = is_pick && cmd_byte1 == id_r;
    wire is_complete = cmd_valid && !cmd_two_bytes && cmd_byte0 == COMPLETE_CODE;
    wire in_inv = state_r == TAGANTI_INVENTORY;
    wire [3:0] new_slot = rnd[3:0];
    wire slot_hit = in_inv && is_slot_call && id_r[3:0] == slot_number_param;
    wire zero_hit = in_inv && is_slot_zero && new_slot == 4'h0;
    wire begin_hit = (state_r == TAGANTI_READY || in_inv) && is_begin_inv;

    always_comb begin
        state_nxt = state_r;
        id_nxt = id_r;
        unique case (state_r)
            TAGANTI_READY: begin
                // only begin-inventory leaves ready
                if (is_begin_inv) begin
                    state_nxt = TAGANTI_INVENTORY;
                    id_nxt = rnd[15:8];
                end else if (!id_loaded_r) begin
                    // ready tag holds a random id from its first cycle
                    id_nxt = rnd[7:0];
                end
            end
            TAGANTI_INVENTORY: begin
                if (is_begin_inv) begin
                    id_nxt = rnd[15:8];
                end else if (is_slot_zero) begin
                    id_nxt = {id_r[7:4], new_slot};
                end else if (pick_match) begin
                    state_nxt = TAGANTI_SELECTED;
                end
            end
            TAGANTI_SELECTED: begin
                if (is_pick && !pick_match) begin
                    state_nxt = TAGANTI_DESELECTED;
                end else if (is_complete) begin
                    state_nxt = TAGANTI_DEACTIVATED;
                end
            end
            TAGANTI_DESELECTED: begin
                if (pick_match) begin
                    state_nxt = TAGANTI_SELECTED;
                end
            end
            TAGANTI_DEACTIVATED: begin
                state_nxt = TAGANTI_DEACTIVATED;
            end
            default: begin
                state_nxt = TAGANTI_READY;
            end
        endcase
    end

    // answer carries the id as it stands after any redraw
    wire answer_nxt = begin_hit || zero_hit || slot_hit;

    logic id_loaded_r;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= TAGANTI_READY;
            id_r <= 8'h00;
            answer_valid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            id_r <= id_nxt;
            answer_valid_r <= answer_nxt;
        end
    end

    // power-up id: the lfsr keeps running while in ready, so the first
    // begin-inventory draws a fresh value; ready id is the lfsr snapshot
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            id_loaded_r <= 1'b0;
        end else begin
            id_loaded_r <= 1'b1;
        end
    end

    assign answer_valid = answer_valid_r;
    assign tag_short_identifier = id_r;
    assign tag_state = state_r;

    a_ready_silent: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_r == TAGANTI_READY && !is_begin_inv) |=> !answer_valid_r)
        else $error("ready tag answered a non begin command");
    a_slot_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        ((is_slot_call || is_slot_zero) && !in_inv) |=> !answer_valid_r)
        else $error("slot command answered outside inventory");
    a_begin_answer: assert property (@(posedge mclk) disable iff (!reset_n)
        (is_begin_inv && (state_r == TAGANTI_READY || in_inv)) |=>
        (answer_valid_r && state_r == TAGANTI_INVENTORY))
        else $error("begin-inventory not answered");
    a_zero_index: assert property (@(posedge mclk) disable iff (!reset_n)
        (in_inv && is_slot_zero) |=> (answer_valid_r == (id_r[3:0] == 4'h0)))
        else $error("slot zero answer mismatch");
    a_slot_match: assert property (@(posedge mclk) disable iff (!reset_n)
        (in_inv && is_slot_call) |=> (answer_valid_r == (id_r[3:0] == $past(cmd_byte0[7:4]))))
        else $error("slot call answer mismatch");
    a_slot_keeps: assert property (@(posedge mclk) disable iff (!reset_n)
        (in_inv && is_slot_call) |=> $stable(id_r))
        else $error("slot call changed identifier");
    a_zero_upper: assert property (@(posedge mclk) disable iff (!reset_n)
        (in_inv && is_slot_zero) |=> (id_r[7:4] == $past(id_r[7:4])))
        else $error("slot zero changed upper identifier");
    a_ready_loaded: assert property (@(posedge mclk) disable iff (!reset_n)
        (!id_loaded_r && state_r == TAGANTI_READY && !is_begin_inv) |=> (id_r == $past(rnd[7:0])))
        else $error("ready identifier not drawn");
    a_deact_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_r == TAGANTI_DEACTIVATED) |=> (!answer_valid_r && state_r == TAGANTI_DEACTIVATED))
        else $error("deactivated tag left state");

    c_begin: cover property (@(posedge mclk) disable iff (!reset_n) begin_hit);
    c_zero: cover property (@(posedge mclk) disable iff (!reset_n) zero_hit);
    c_slot: cover property (@(posedge mclk) disable iff (!reset_n) slot_hit);
    c_select: cover property (@(posedge mclk) disable iff (!reset_n) in_inv && pick_match);
endmodule
`default_nettype wire

// [verification/taganti_reader_model.sv]
// reader-side model issuing request frames to the responder
`timescale 1ns/1ps
`default_nettype none
module taganti_reader_model
    import taganti_pkg::*;
(
    // clock
    input wire logic mclk,
    // request frame out
    output logic cmd_valid,
    output logic [7:0] cmd_byte0,
    output logic [7:0] cmd_byte1,
    output logic cmd_two_bytes
);
    initial begin
        cmd_valid = 1'b0;
        cmd_byte0 = 8'h00;
        cmd_byte1 = 8'h00;
        cmd_two_bytes = 1'b0;
    end
    // one pulse per frame; bytes scrambled afterwards so stale values cannot pass
    task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic two);
        @(posedge mclk);
        #1;
        cmd_valid = 1'b1;
        cmd_byte0 = b0;
        cmd_byte1 = b1;
        cmd_two_bytes = two;
        @(posedge mclk);
        #1;
        cmd_valid = 1'b0;
        cmd_byte0 = ~b0;
        cmd_byte1 = ~b1;
    endtask
endmodule
`default_nettype wire

// [verification/tag_anticollision_sequence_tb_top.sv]
// self-checking bench for the tag anticollision responder
`timescale 1ns/1ps
`default_nettype none
module tag_anticollision_sequence_tb_top;
    import taganti_pkg::*;
    logic mclk;
    logic reset_n;
    logic cmd_valid;
    logic [7:0] cmd_byte0;
    logic [7:0] cmd_byte1;
    logic cmd_two_bytes;
    logic answer_valid;
    logic [7:0] tag_short_identifier;
    logic [2:0] tag_state;
    int mismatches;
    int samples_checked;
    int m_state;
    logic [7:0] m_id;
    taganti_responder dut_u (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_byte0(cmd_byte0),
        .cmd_byte1(cmd_byte1), .cmd_two_bytes(cmd_two_bytes), .answer_valid(answer_valid),
        .tag_short_identifier(tag_short_identifier), .tag_state(tag_state));
    taganti_reader_model rdr_u (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_byte0(cmd_byte0),
        .cmd_byte1(cmd_byte1), .cmd_two_bytes(cmd_two_bytes));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // model states: 0 ready, 1 inventory, 2 selected, 3 deselected, 4 deactivated
    task automatic step(input logic [7:0] b0, input logic [7:0] b1, input logic two);
        logic ans;
        ans = 1'b0;
        rdr_u.send(b0, b1, two);
        if (two && b0 == CMD_PREFIX && b1 == SUB_BEGIN_INV && m_state < 2) begin
            ans = 1'b1;
            m_state = 1;
            m_id = tag_short_identifier; // random draw can only be tracked
        end else if (two && b0 == CMD_PREFIX && b1 == SUB_SLOT_ZERO && m_state == 1) begin
            check(tag_short_identifier[7:4], m_id[7:4]);
            m_id = tag_short_identifier;
            ans = (m_id[3:0] == 4'h0);
        end else if (!two && b0[3:0] == SLOT_CALL_NIBBLE && b0[7:4] != 4'h0) begin
            ans = (m_state == 1 && m_id[3:0] == b0[7:4]);
        end else if (two && b0 == PICK_CODE && m_state > 0 && m_state < 4) begin
            if (b1 == m_id) m_state = 2;
            else if (m_state == 2) m_state = 3;
        end else if (!two && b0 == COMPLETE_CODE && m_state == 2) begin
            m_state = 4;
        end
        check({7'h00, answer_valid}, {7'h00, ans});
        check({5'h00, tag_state}, 8'(m_state));
        if (m_state == 1) check(tag_short_identifier, m_id);
    endtask
    task automatic sweep();
        step(CMD_PREFIX, SUB_SLOT_ZERO, 1'b1);
        for (int n = 1; n < 16; n++) step({n[3:0], SLOT_CALL_NIBBLE}, 8'h00, 1'b0);
    endtask
    initial begin
        #2000000;
        mismatches++;
        finish_test();
    end
    initial begin
        mismatches = 0;
        samples_checked = 0;
        m_state = 0;
        m_id = 8'h00;
        reset_n = 1'b0;
        void'($urandom(37));
        repeat (12) @(posedge mclk);
        #1 reset_n = 1'b1;
        check({5'h00, tag_state}, 8'h00);
        sweep();
        step(PICK_CODE, 8'($urandom_range(255, 0)), 1'b1);
        step(CMD_PREFIX, SUB_BEGIN_INV, 1'b1);
        repeat (6) sweep();
        step(8'h06, 8'h00, 1'b0);
        repeat (20) step({4'($urandom_range(15, 1)), SLOT_CALL_NIBBLE}, 8'h00, 1'b0);
        step(CMD_PREFIX, SUB_BEGIN_INV, 1'b1);
        step(PICK_CODE, m_id ^ 8'($urandom_range(255, 1)), 1'b1);
        step(PICK_CODE, m_id, 1'b1);
        step(CMD_PREFIX, SUB_SLOT_ZERO, 1'b1);
        step({m_id[3:0], SLOT_CALL_NIBBLE}, 8'h00, 1'b0);
        step(PICK_CODE, ~m_id, 1'b1);
        step(CMD_PREFIX, SUB_BEGIN_INV, 1'b1);
        step(PICK_CODE, m_id, 1'b1);
        step(COMPLETE_CODE, 8'h00, 1'b0);
        step(CMD_PREFIX, SUB_BEGIN_INV, 1'b1);
        // mid-run reset must return the tag to ready
        #1 reset_n = 1'b0;
        repeat (3) @(posedge mclk);
        #1 reset_n = 1'b1;
        m_state = 0;
        check({5'h00, tag_state}, 8'h00);
        step(CMD_PREFIX, SUB_SLOT_ZERO, 1'b1);
        step(CMD_PREFIX, SUB_BEGIN_INV, 1'b1);
        sweep();
        finish_test();
    end
endmodule
`default_nettype wire
